// *** clk_sync_pkg.sv ***
// Purpose: shared constants and types for the reference and holdover control
// Assumes: 40 MHz bus clock, AHB-Lite register access
// Notes: offsets are byte addresses within the slave window
package clk_sync_pkg;
	localparam int NLOOP = 3;
	localparam int NREF  = 4;
	localparam int NMON  = 5;
	// register offsets
	localparam logic [4:0] O_CTRL  = 5'h00;
	localparam logic [4:0] O_PRIO  = 5'h04;
	localparam logic [4:0] O_STEP  = 5'h08;
	localparam logic [4:0] O_STAT  = 5'h0C;
	localparam logic [4:0] O_DEN   = 5'h10;
	localparam logic [7:0] O_MONEN = 8'h60;
	localparam logic [7:0] O_REFST = 8'h64;
	localparam logic [7:0] O_MISC  = 8'h68;
	localparam logic [7:0] O_THR   = 8'h70;
	// field positions
	localparam int STAT_INC = 0;
	localparam int STAT_DEC = 1;
	localparam int MISC_SYNC = 4;
	// reset values
	localparam logic [12:0] CTRL_RST  = 13'h0002;
	localparam logic [7:0]  PRIO_RST  = 8'hE4;
	localparam logic [31:0] STEP_RST  = 32'h0000_0000;
	localparam logic [23:0] DEN_RST   = 24'h00_0001;
	localparam logic [19:0] MONEN_RST = 20'hF_FFFF;
	localparam logic [31:0] THR_RST   = 32'h0000_0000;
	localparam logic [3:0]  PDIV_RST  = 4'h1;
	// timing
	localparam int CLK_MHZ      = 40;
	localparam int QUAL_TIME_US = 10;
	localparam int QUAL_CYC     = QUAL_TIME_US * CLK_MHZ;
	localparam int HIST_SHIFT   = 8;
	typedef enum logic [3:0] {
		ST_FREE = 4'b0001,
		ST_QUAL = 4'b0010,
		ST_LOCK = 4'b0100,
		ST_HOLD = 4'b1000
	} loop_state_t;
	typedef struct packed {
		logic [1:0] apll_src;
		logic       apll_casc;
		logic [1:0] casc_src;
		logic       use_casc;
		logic       denominator_select;
		logic       dco_en;
		logic       pin_sel;
		logic [1:0] man_sel;
		logic       auto_en;
		logic       pdn;
	} loop_ctrl_t;
endpackage : clk_sync_pkg

// *** clk_sync_ctrl.sv ***
// Purpose: reference selection, holdover and oscillator stepping for three loops
// Assumes: monitor trips and tuning words arrive synchronous to hclk
// Notes: reads take one wait state, writes none
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - automatic mode picks reference by priority among monitor-valid inputs
// - manual selection by register field or by select pin
// - reference lost when any enabled monitor trips
// - on loss switch hitlessly to a valid input, else holdover
// - every monitor threshold and enable programmable per input
// - holdover starts from averaged tuning word history
// - increment or decrement adds or subtracts step to numerator
// - step resolution finer than one ppt, software or pin command
// - loop has converter, filter and 40-bit fractional feedback divider
// - locked loop drives analog numerator against fixed 40-bit denominator
// - programmable 24-bit denominator offered without digital loop control
// - post-divider value 1 bypasses the divider
// - loop reference mux picks external input or cascade divider
// - analog reference mux picks crystal input or cascade divider
// - output dividers synchronise on command to align phases
// - monitor and lock status shown on pins and readable registers
// - oscillator step propagates to outputs and cascaded domains
// - lock acquisition starts only after minimum qualification time
// - denominator select 0 picks fixed 40-bit, 1 picks 24-bit
module clk_sync_ctrl
	import clk_sync_pkg::*;
(
	// clock and reset
	input  wire logic                       hclk,
	input  wire logic                       hresetn,
	// ahb-lite slave
	input  wire logic                       hsel,
	input  wire logic [31:0]                haddr,
	input  wire logic [1:0]                 htrans,
	input  wire logic                       hwrite,
	input  wire logic [2:0]                 hsize,
	input  wire logic [31:0]                hwdata,
	input  wire logic                       hready,
	output logic      [31:0]                hrdata,
	output logic                            hreadyout,
	output logic                            hresp,
	// reference monitors
	input  wire logic [NREF*NMON-1:0]       mon_trip,
	output logic      [NREF*NMON-1:0]       mon_enable,
	output logic      [NREF-1:0][31:0]      mon_threshold,
	// loop side
	input  wire logic [NLOOP-1:0][1:0]      ref_sel_pin,
	input  wire logic [NLOOP-1:0]           dco_inc_pin,
	input  wire logic [NLOOP-1:0]           dco_dec_pin,
	input  wire logic [NLOOP-1:0][39:0]     tuning_word,
	output logic      [NLOOP-1:0][2:0]      loop_ref_sel,
	output logic      [NLOOP-1:0][2:0]      apll_ref_sel,
	output logic      [NLOOP-1:0][39:0]     feedback_divider_num,
	output logic      [NLOOP-1:0]           denominator_select,
	output logic      [NLOOP-1:0][23:0]     denominator_prog,
	output logic      [NLOOP-1:0]           acq_enable,
	output logic      [NLOOP-1:0]           holdover,
	// distribution and status
	output logic      [3:0]                 resonator_postdiv,
	output logic                            postdiv_bypass,
	output logic                            sync_pulse,
	output logic      [NREF+NLOOP-1:0]      status_pins
);
	logic             rd_pend_q;
	logic             wr_q;
	logic [7:0]       addr_q;
	logic [31:0]      rdata_q;
	logic             rdy_q;
	logic [31:0]      rd_d;
	logic [19:0]      monen_q;
	logic [31:0]      thr_q [NREF];
	logic [3:0]       pdiv_q;
	logic             pbyp_q;
	logic             sync_q;
	logic [NREF-1:0]  lost_d;
	logic [NREF-1:0]  lost_q;
	logic [NREF+NLOOP-1:0] stpin_q;
	loop_ctrl_t       ctrl_q [NLOOP];
	logic [7:0]       prio_q [NLOOP];
	logic [31:0]      step_q [NLOOP];
	logic [23:0]      den_q  [NLOOP];
	loop_state_t      st_q   [NLOOP];
	logic [1:0]       sel_q  [NLOOP];
	logic [39:0]      num_q  [NLOOP];
	logic [2:0]       lref_q [NLOOP];
	logic [2:0]       aref_q [NLOOP];
	wire  logic       addr_ph = hsel && hready && htrans[1];
	wire  logic [1:0] wloop   = addr_q[6:5];

	// bus address phase capture
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q      <= 1'b0;
			rd_pend_q <= 1'b0;
			addr_q    <= 8'h00;
		end else begin
			wr_q      <= addr_ph && hwrite;
			rd_pend_q <= addr_ph && !hwrite;
			if (addr_ph) begin
				addr_q <= haddr[7:0];
			end
		end
	end

	// read data with one wait state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdy_q   <= 1'b1;
			rdata_q <= 32'h0000_0000;
		end else begin
			rdy_q <= !(addr_ph && !hwrite);
			if (rd_pend_q) begin
				rdata_q <= rd_d;
			end
		end
	end

	always_comb begin
		rd_d = 32'h0000_0000;
		if (addr_q[7:5] < 3'(NLOOP)) begin
			case (addr_q[4:0])
				O_CTRL: rd_d = {19'h0, ctrl_q[wloop]};
				O_PRIO: rd_d = {24'h0, prio_q[wloop]};
				O_STEP: rd_d = step_q[wloop];
				O_STAT: rd_d = {22'h0, lost_q, st_q[wloop], sel_q[wloop]};
				O_DEN:  rd_d = {8'h0, den_q[wloop]};
				default: rd_d = 32'h0000_0000;
			endcase
		end else if (addr_q == O_MONEN) begin
			rd_d = {12'h0, monen_q};
		end else if (addr_q == O_REFST) begin
			rd_d = {25'h0, stpin_q};
		end else if (addr_q == O_MISC) begin
			rd_d = {28'h0, pdiv_q};
		end else if (addr_q[7:4] == O_THR[7:4]) begin
			rd_d = thr_q[addr_q[3:2]];
		end
	end

	// global registers
	// per input thresholds
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			monen_q <= MONEN_RST;
			pdiv_q  <= PDIV_RST;
			for (int r = 0; r < NREF; r++) begin
				thr_q[r] <= THR_RST;
			end
		end else if (wr_q) begin
			if (addr_q == O_MONEN) begin
				monen_q <= hwdata[19:0];
			end
			if (addr_q == O_MISC) begin
				pdiv_q <= hwdata[3:0];
			end
			if (addr_q[7:4] == O_THR[7:4]) begin
				thr_q[addr_q[3:2]] <= hwdata;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync_q <= 1'b0;
			pbyp_q <= 1'b0;
		end else begin
			sync_q <= wr_q && addr_q == O_MISC && hwdata[MISC_SYNC];
			pbyp_q <= pdiv_q == 4'h1;
		end
	end

	always_comb begin
		for (int r = 0; r < NREF; r++) begin
			lost_d[r] = |(mon_trip[r*NMON +: NMON] & monen_q[r*NMON +: NMON]);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lost_q  <= '0;
			stpin_q <= '0;
		end else begin
			lost_q <= lost_d;
			for (int l = 0; l < NLOOP; l++) begin
				stpin_q[NREF+l] <= st_q[l] == ST_LOCK;
			end
			stpin_q[NREF-1:0] <= lost_q;
		end
	end

	for (genvar l = 0; l < NLOOP; l++) begin : g_loop
		localparam logic [1:0] LI = 2'(l);
		wire  logic  lwr = wr_q && addr_q[7:5] == {1'b0, LI};
		logic        found;
		logic [1:0]  best;
		logic [1:0]  bp;
		logic [1:0]  msel;
		logic [8:0]  qcnt_q;
		logic [39:0] hist_q;
		logic [39:0] dco_q;
		logic [39:0] base;
		logic        inc;
		logic        dec;

		// loop registers
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				ctrl_q[l] <= CTRL_RST;
				prio_q[l] <= PRIO_RST;
				step_q[l] <= STEP_RST;
				den_q[l]  <= DEN_RST;
			end else if (lwr) begin
				case (addr_q[4:0])
					O_CTRL: ctrl_q[l] <= hwdata[12:0];
					O_PRIO: prio_q[l] <= hwdata[7:0];
					O_STEP: step_q[l] <= hwdata;
					O_DEN:  den_q[l]  <= hwdata[23:0];
					default: ;
				endcase
			end
		end

		// candidate reference
		always_comb begin
			found = 1'b0;
			best  = sel_q[l];
			bp    = 2'h3;
			msel  = ctrl_q[l].pin_sel ? ref_sel_pin[l] : ctrl_q[l].man_sel;
			if (ctrl_q[l].use_casc) begin
				found = 1'b1;
			end else if (ctrl_q[l].auto_en) begin
				for (int r = NREF - 1; r >= 0; r--) begin
					if (!lost_q[r] && (!found || prio_q[l][2*r +: 2] <= bp)) begin
						found = 1'b1;
						bp    = prio_q[l][2*r +: 2];
						best  = 2'(r);
					end
				end
			end else begin
				found = !lost_q[msel];
				best  = msel;
			end
		end

		// loop state
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				st_q[l]  <= ST_FREE;
				sel_q[l] <= 2'h0;
				qcnt_q   <= 9'h000;
			end else if (ctrl_q[l].pdn) begin
				st_q[l] <= ST_FREE;
			end else begin
				case (st_q[l])
					ST_FREE, ST_HOLD: begin
						qcnt_q <= 9'h000;
						if (found) begin
							st_q[l]  <= ST_QUAL;
							sel_q[l] <= best;
						end
					end
					ST_QUAL: begin
						sel_q[l] <= best;
						qcnt_q   <= qcnt_q + 9'h001;
						if (!found) begin
							st_q[l] <= ST_FREE;
						end else if (qcnt_q == 9'(QUAL_CYC - 1)) begin
							st_q[l] <= ST_LOCK;
						end
					end
					ST_LOCK: begin
						if (found) begin
							sel_q[l] <= best;
						end else begin
							st_q[l] <= ST_HOLD;
						end
					end
					default: st_q[l] <= ST_FREE;
				endcase
			end
		end

		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				hist_q <= 40'h00_0000_0000;
			end else if (st_q[l] == ST_LOCK) begin
				hist_q <= hist_q + 40'($signed(tuning_word[l] - hist_q) >>> HIST_SHIFT);
			end
		end

		assign inc = dco_inc_pin[l] || (lwr && addr_q[4:0] == O_STAT && hwdata[STAT_INC]);
		assign dec = dco_dec_pin[l] || (lwr && addr_q[4:0] == O_STAT && hwdata[STAT_DEC]);

		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				dco_q <= 40'h00_0000_0000;
			end else if (!ctrl_q[l].dco_en) begin
				dco_q <= 40'h00_0000_0000;
			end else if (inc && !dec) begin
				dco_q <= dco_q + {8'h00, step_q[l]};
			end else if (dec && !inc) begin
				dco_q <= dco_q - {8'h00, step_q[l]};
			end
		end

		assign base = st_q[l] == ST_LOCK ? tuning_word[l] : hist_q;

		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				num_q[l]  <= 40'h00_0000_0000;
				lref_q[l] <= 3'h0;
				aref_q[l] <= 3'h0;
			end else begin
				num_q[l]  <= base + dco_q;
				lref_q[l] <= ctrl_q[l].use_casc ? {1'b1, ctrl_q[l].casc_src} : {1'b0, sel_q[l]};
				aref_q[l] <= {ctrl_q[l].apll_casc, ctrl_q[l].apll_src};
			end
		end

		assign loop_ref_sel[l]         = lref_q[l];
		assign apll_ref_sel[l]         = aref_q[l];
		assign feedback_divider_num[l] = num_q[l];
		assign denominator_select[l]   = ctrl_q[l].denominator_select;
		assign denominator_prog[l]     = den_q[l];
		assign acq_enable[l]           = st_q[l][2];
		assign holdover[l]             = st_q[l][3];
	end

	for (genvar r = 0; r < NREF; r++) begin : g_thr
		assign mon_threshold[r] = thr_q[r];
	end

	assign hrdata            = rdata_q;
	assign hreadyout         = rdy_q;
	assign hresp             = 1'b0;
	assign mon_enable        = monen_q;
	assign resonator_postdiv = pdiv_q;
	assign postdiv_bypass    = pbyp_q;
	assign sync_pulse        = sync_q;
	assign status_pins       = stpin_q;
endmodule : clk_sync_ctrl
`default_nettype wire

// *** clk_sync_ctrl_sva.sv ***
// Purpose: port checker for the reference and holdover control
// Assumes: one clock domain, hclk
// Notes: attached by bind to every instance
`timescale 1ns/100ps
`default_nettype none
module clk_sync_ctrl_sva
	import clk_sync_pkg::*;
(
	// watched ports
	input wire logic                   hclk,
	input wire logic                   hresetn,
	input wire logic                   hsel,
	input wire logic [1:0]             htrans,
	input wire logic                   hwrite,
	input wire logic                   hready,
	input wire logic                   hreadyout,
	input wire logic [NREF*NMON-1:0]   mon_trip,
	input wire logic [NREF*NMON-1:0]   mon_enable,
	input wire logic [NLOOP-1:0]       acq_enable,
	input wire logic [NLOOP-1:0]       holdover,
	input wire logic [3:0]             resonator_postdiv,
	input wire logic                   postdiv_bypass,
	input wire logic                   sync_pulse,
	input wire logic [NREF+NLOOP-1:0]  status_pins
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic       take;
	logic       trip0;
	logic [9:0] low_q;
	assign take  = hsel & hready & htrans[1];
	assign trip0 = |(mon_trip[4:0] & mon_enable[4:0]);
	// cycles spent without lock on loop 0
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			low_q <= '0;
		else if (acq_enable[0])
			low_q <= '0;
		else if (low_q != 10'h3FF)
			low_q <= low_q + 10'h001;
	end
	a_qual_time: assert property ($rose(acq_enable[0]) |-> low_q >= QUAL_CYC)
		else $error("lock began before qualification ended");
	a_bypass_div: assert property ($past(hresetn) |->
		postdiv_bypass == ($past(resonator_postdiv) == 4'h1))
		else $error("post-divider bypass wrong");
	a_state_excl: assert property (!(|(acq_enable & holdover)))
		else $error("lock and holdover together");
	a_hold_entry: assert property ($rose(holdover[0]) |->
		(&status_pins[3:0]) || (&($past(status_pins[3:0]))))
		else $error("holdover with a valid input left");
	a_hold_lock: assert property ($rose(holdover[0]) |-> $past(acq_enable[0]))
		else $error("holdover entered without lock history");
	a_lost_flag: assert property (trip0 [*3] |-> status_pins[0])
		else $error("lost flag missing after trip");
	a_mask_quiet: assert property ((!trip0) [*3] |-> !status_pins[0])
		else $error("lost flag without enabled trip");
	a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	a_write_fast: assert property (take && hwrite |=> hreadyout)
		else $error("write stalled");
	a_sync_single: assert property (sync_pulse |=> !sync_pulse)
		else $error("sync pulse too long");
endmodule : clk_sync_ctrl_sva
bind clk_sync_ctrl clk_sync_ctrl_sva u_sva (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
	.hready(hready), .hreadyout(hreadyout), .mon_trip(mon_trip), .mon_enable(mon_enable),
	.acq_enable(acq_enable), .holdover(holdover), .resonator_postdiv(resonator_postdiv),
	.postdiv_bypass(postdiv_bypass), .sync_pulse(sync_pulse), .status_pins(status_pins)
);
`default_nettype wire

// *** clk_sync_ref_src.sv ***
// Purpose: reference sources and loop filter words facing the block
// Assumes: failures commanded by the bench
// Notes: a failed input trips one chosen monitor kind
`timescale 1ns/100ps
`default_nettype none
module clk_sync_ref_src
	import clk_sync_pkg::*;
(
	// bench commands
	input  wire logic [NREF-1:0]        fail,
	input  wire logic [2:0]             fail_mon,
	// monitor results and tuning words
	output logic      [NREF*NMON-1:0]   mon_trip,
	output logic      [NLOOP-1:0][39:0] tuning_word
);
	always_comb begin
		mon_trip = '0;
		for (int r = 0; r < NREF; r++) begin
			if (fail[r])
				mon_trip[r*NMON+int'(fail_mon)] = 1'b1;
		end
	end
	always_comb begin
		for (int l = 0; l < NLOOP; l++) begin
			tuning_word[l] = 40'h80_0000_0000 + 40'(l);
		end
	end
endmodule : clk_sync_ref_src
`default_nettype wire

// *** clk_sync_ctrl_tb_top.sv ***
// Purpose: self-checking bench for the reference and holdover control
// Assumes: one ahb-lite master, 40 MHz clock
// Notes: loop 0 carries the selection scenarios
`timescale 1ns/100ps
`default_nettype none
module clk_sync_ctrl_tb_top
	import clk_sync_pkg::*;
;
	logic                      hclk = 1'b0;
	logic                      hresetn = 1'b0;
	logic                      hsel = 1'b0;
	logic [31:0]               haddr = '0;
	logic [1:0]                htrans = 2'h0;
	logic                      hwrite = 1'b0;
	logic [2:0]                hsize = 3'h2;
	logic [31:0]               hwdata = '0;
	logic [31:0]               hrdata, q;
	logic                      hreadyout, hresp, postdiv_bypass, sync_pulse, seen;
	logic [NLOOP-1:0][1:0]     ref_sel_pin = '0;
	logic [NLOOP-1:0]          dco_inc_pin = '0;
	logic [NLOOP-1:0]          dco_dec_pin = '0;
	logic [NREF-1:0]           fail = '0;
	logic [2:0]                fail_mon = '0;
	logic [NREF*NMON-1:0]      mon_trip, mon_enable;
	logic [NREF-1:0][31:0]     mon_threshold;
	logic [NLOOP-1:0][39:0]    tuning_word, feedback_divider_num;
	logic [NLOOP-1:0][2:0]     loop_ref_sel, apll_ref_sel;
	logic [NLOOP-1:0]          denominator_select, acq_enable, holdover;
	logic [NLOOP-1:0][23:0]    denominator_prog;
	logic [3:0]                resonator_postdiv;
	logic [NREF+NLOOP-1:0]     status_pins;
	logic [39:0]               n0;
	int                        num_errors = 0;
	int                        checked = 0;
	always #12.5 hclk = ~hclk;
	clk_sync_ctrl DUT (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.mon_trip(mon_trip), .mon_enable(mon_enable), .mon_threshold(mon_threshold),
		.ref_sel_pin(ref_sel_pin), .dco_inc_pin(dco_inc_pin), .dco_dec_pin(dco_dec_pin),
		.tuning_word(tuning_word), .loop_ref_sel(loop_ref_sel), .apll_ref_sel(apll_ref_sel),
		.feedback_divider_num(feedback_divider_num), .denominator_select(denominator_select),
		.denominator_prog(denominator_prog), .acq_enable(acq_enable), .holdover(holdover),
		.resonator_postdiv(resonator_postdiv), .postdiv_bypass(postdiv_bypass),
		.sync_pulse(sync_pulse), .status_pins(status_pins)
	);
	clk_sync_ref_src u_src (
		.fail(fail), .fail_mon(fail_mon), .mon_trip(mon_trip), .tuning_word(tuning_word)
	);
	task automatic conclude;
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : conclude
	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %0h exp %0h", $time, got, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge hclk);
	endtask : cyc
	task automatic rdy;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1) begin
			num_errors++;
			conclude();
		end
	endtask : rdy
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		htrans <= 2'h2;
		hwrite <= w;
		rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rdy();
		q = hrdata;
	endtask : xfer
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0000_0000);
		chk(q, exp);
	endtask : rd
	task automatic wlock;
		for (int i = 0; i < 600 && acq_enable[0] !== 1'b1; i++)
			@(posedge hclk);
		if (acq_enable[0] !== 1'b1) begin
			num_errors++;
			conclude();
		end
	endtask : wlock
	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(8'h00, 32'h0000_0002);
		rd(8'h04, 32'h0000_00E4);
		rd(8'h30, 32'h0000_0001);
		rd(8'h60, 32'h000F_FFFF);
		rd(8'h34, 32'h0000_0000);
		chk(postdiv_bypass, 1'b1);
		cyc(150);
		chk(acq_enable[0], 1'b0);
		wlock();
		chk(acq_enable[0], 1'b1);
		chk(loop_ref_sel[0], 3'h0);
		rd(8'h0C, 32'h0000_0010);
		for (int m = 0; m < NMON; m++) begin
			fail_mon <= 3'(m);
			fail <= 4'h1;
			cyc(6);
			chk(loop_ref_sel[0], 3'h1);
			chk(holdover[0], 1'b0);
			fail <= 4'h0;
			cyc(6);
		end
		xfer(1'b1, 8'h60, 32'h000F_FFE0);
		fail <= 4'h1;
		cyc(6);
		chk(loop_ref_sel[0], 3'h0);
		chk(mon_enable, 40'h0_000F_FFE0);
		xfer(1'b1, 8'h74, 32'h0000_ABCD);
		cyc(1);
		chk(mon_threshold[1], 32'h0000_ABCD);
		rd(8'h74, 32'h0000_ABCD);
		xfer(1'b1, 8'h60, 32'h000F_FFFF);
		wlock();
		fail <= 4'hF;
		cyc(6);
		chk(holdover[0], 1'b1);
		chk(status_pins[3:0], 4'hF);
		rd(8'h64, 32'h0000_000F);
		chk(hresp, 1'b0);
		xfer(1'b1, 8'h08, 32'h0000_0007);
		xfer(1'b1, 8'h00, 32'h0000_0022);
		cyc(3);
		n0 = feedback_divider_num[0];
		xfer(1'b1, 8'h0C, 32'h0000_0001);
		cyc(3);
		chk(feedback_divider_num[0], n0 + 40'h7);
		dco_inc_pin[0] <= 1'b1;
		dco_dec_pin[0] <= 1'b1;
		@(posedge hclk);
		dco_inc_pin[0] <= 1'b0;
		dco_dec_pin[0] <= 1'b0;
		cyc(3);
		chk(feedback_divider_num[0], n0 + 40'h7);
		xfer(1'b1, 8'h0C, 32'h0000_0002);
		cyc(3);
		chk(feedback_divider_num[0], n0);
		fail <= 4'h0;
		xfer(1'b1, 8'h00, 32'h0000_000C);
		cyc(6);
		chk(loop_ref_sel[0], 3'h3);
		ref_sel_pin[0] <= 2'h2;
		xfer(1'b1, 8'h00, 32'h0000_0010);
		cyc(6);
		chk(loop_ref_sel[0], 3'h2);
		// pair sources apart, 24-bit denominator programmed, unused loops down
		xfer(1'b1, 8'h20, 32'h0000_0001);
		xfer(1'b1, 8'h40, 32'h0000_0001);
		xfer(1'b1, 8'h00, 32'h0000_15C0);
		xfer(1'b1, 8'h10, 32'h0012_3456);
		cyc(3);
		chk(loop_ref_sel[0], 3'h5);
		chk(apll_ref_sel[0], 3'h6);
		chk(denominator_select[0], 1'b1);
		chk(denominator_prog[0], 24'h12_3456);
		xfer(1'b1, 8'h68, 32'h0000_0002);
		cyc(2);
		chk(resonator_postdiv, 4'h2);
		chk(postdiv_bypass, 1'b0);
		seen = 1'b0;
		xfer(1'b1, 8'h68, 32'h0000_0011);
		for (int i = 0; i < 4; i++) begin
			@(posedge hclk);
			seen = seen | sync_pulse;
		end
		chk(seen, 1'b1);
		chk(postdiv_bypass, 1'b1);
		conclude();
	end
endmodule : clk_sync_ctrl_tb_top
`default_nettype wire
